// ### core/csf_pkg.sv
package csf_pkg;

	// device clock and transmit period
	localparam int CLK_HZ = 200_000_000;
	localparam int PERIOD_MS = 10;
	localparam int PERIOD_CYC = (CLK_HZ / 1000) * PERIOD_MS;
	// reporting deadline for a plausibility fault; one period is far inside it
	localparam int FTTI_MS = 500;
	// bit timing reference tolerance the clock source must meet, in ppm
	localparam int OSC_TOL_PPM = 2700;

	localparam logic [10:0] FRAME_ID = 11'h3c2;
	localparam int FRAME_BYTES = 8;
	localparam int FIFO_DEPTH = 4;

	// start-up supply window, millivolts
	localparam int SUPPLY_MIN_MV = 7800;
	localparam int SUPPLY_MAX_MV = 16200;

	// current thresholds, milliamps; DIG_CLAMP_A in amps
	localparam int PLAUS_BAND_MA = 220000;
	localparam int PLAUS_TOP_MA = 1500000;
	localparam int PLAUS_GAP_MA = 44000;
	localparam int PLAUS_PCT = 20;
	localparam int OVERCUR_MA = 1600000;
	localparam int CLAMP_MA = 1550000;
	localparam int PEAK_MA = 1700000;
	localparam int DIG_CLAMP_A = 1550;
	localparam int MA_PER_A = 1000;

	// output codes
	localparam logic [23:0] ANA_POS_CLAMP = 24'h97a6b0;
	localparam logic [23:0] ANA_NEG_CLAMP = 24'h685950;
	localparam logic [23:0] ANA_OVER = 24'hffffff;
	localparam logic [15:0] DIG_POS_CLAMP = 16'h860e;
	localparam logic [15:0] DIG_NEG_CLAMP = 16'h79f2;
	localparam logic [7:0] RESERVED_BYTE = 8'h00;

	// byte 0 layout
	localparam int SEQ_POS = 4;
	localparam int SUP_POS = 2;
	localparam int ERR_POS = 1;
	localparam int PLAUS_POS = 0;
	localparam logic [3:0] SEQ_FIRST = 4'h0;
	localparam logic [3:0] SEQ_LAST = 4'hf;
	localparam logic [3:0] SEQ_WRAP = 4'h1;
	localparam logic [1:0] SUPPLY_UNAVAIL = 2'h3;

	// checksum
	localparam logic [7:0] CRC_POLY = 8'h1d;
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_XOROUT = 8'hff;

	typedef enum logic [3:0] {
		ST_INIT = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_SEND = 4'b0100,
		ST_HALT = 4'b1000
	} csf_state_e;

endpackage

// ### core/csf_crc8.sv
`timescale 1ns/1ps
module csf_crc8 (
	input wire logic [55:0] msg,
	output logic [7:0] crc
);
	import csf_pkg::*;

	always_comb begin
		logic [7:0] c;
		logic fb;
		c = CRC_INIT;
		fb = 1'b0;
		// msb of byte 0 first
		for (int i = 55; i >= 0; i--) begin
			fb = c[7] ^ msg[i];
			c = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ CRC_POLY;
			end
		end
		crc = c ^ CRC_XOROUT;
	end
endmodule

// ### core/csf_fifo.sv
`timescale 1ns/1ps
module csf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	import csf_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic next_outValid;
	logic push;
	logic pop;

	assign inReady = (count != CW'(DEPTH));
	assign outData = mem[0];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// head always sits in entry 0 so the output is a flop
	always_comb begin
		logic [CW-1:0] wr;
		wr = count - CW'(pop);
		for (int i = 0; i < DEPTH; i++) begin
			next_mem[i] = mem[i];
			if (pop) begin
				next_mem[i] = (i == DEPTH - 1) ? mem[i] : mem[(i + 1) % DEPTH];
			end
			if (push && wr == CW'(i)) begin
				next_mem[i] = inData;
			end
		end
		next_count = count + CW'(push) - CW'(pop);
		next_outValid = (next_count != '0);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			outValid <= 1'b0;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			count <= next_count;
			outValid <= next_outValid;
			mem <= next_mem;
		end
	end
endmodule

// ### core/csf_frame_builder.sv
// What this block does
// - CAN 2.0B frames, multi-byte fields big-endian
// - bit timing reference within 0.27 percent
// - no sleep state, always keeps transmitting
// - identifier 0x3C2, one frame every 10 ms
// - counter starts 0, after 15 goes 1
// - supply status 11 when measurement unavailable
// - no frames if start-up supply out of range
// - internal error flag on hardware fault
// - internal error flag above 1600 A
// - plausibility: over 20 percent above 220 A, up to 1500 A
// - plausibility: over 44 A gap within 220 A
// - plausibility raised, data keeps flowing, next frame
// - analog field 24-bit offset binary, milliamps
// - analog clamped at plus/minus 1550 A
// - analog all ones above peak limit
// - digital field 16-bit offset binary, amps
// - digital clamped at plus/minus 1550 A
// - byte 7 is CRC over bytes 0-6
`timescale 1ns/1ps
module csf_frame_builder #(
	parameter int PERIOD_CYCLES = csf_pkg::PERIOD_CYC,
	parameter int DEPTH = csf_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic signed [23:0] analogReading,
	input wire logic signed [15:0] digitalReading,
	input wire logic [15:0] supplyMv,
	input wire logic supplyMeasOk,
	input wire logic [1:0] supplyStatus,
	input wire logic hwFault,
	input wire logic txReady,
	output logic [10:0] frameId,
	output logic [7:0] txData,
	output logic txValid,
	output logic txLast,
	output logic running
);
	import csf_pkg::*;

	csf_state_e state;
	csf_state_e next_state;
	logic [31:0] tickCnt;
	logic [31:0] next_tickCnt;
	logic tick;
	logic [3:0] seq;
	logic [3:0] next_seq;
	logic [2:0] byteIdx;
	logic [2:0] next_byteIdx;
	logic [63:0] frame;
	logic [63:0] next_frame;
	logic next_running;

	// measurement conditioning
	logic [24:0] aMag;
	logic signed [27:0] dMa;
	logic signed [27:0] diff;
	logic [27:0] diffMag;
	logic plausFail;
	logic intErr;
	logic [23:0] anaCode;
	logic signed [15:0] dClamped;
	logic [15:0] digCode;
	logic [1:0] supField;
	logic [7:0] byte0;
	logic [55:0] crcMsg;
	logic [7:0] crcOut;

	logic pushValid;
	logic pushReady;
	logic [7:0] pushData;

	always_comb begin
		aMag = analogReading[23] ? 25'(-$signed({analogReading[23], analogReading}))
			: 25'({1'b0, analogReading});
		dMa = 28'(digitalReading) * 28'(MA_PER_A);
		diff = 28'(analogReading) - dMa;
		diffMag = diff[27] ? 28'(-diff) : 28'(diff);
		plausFail = 1'b0;
		if (aMag <= 25'(PLAUS_BAND_MA)) begin
			plausFail = diffMag > 28'(PLAUS_GAP_MA);
		end else if (aMag <= 25'(PLAUS_TOP_MA)) begin
			// diff over 20 percent of analog, without a divider
			plausFail = 32'(diffMag) * 32'(100) > 32'(aMag) * 32'(PLAUS_PCT);
		end
		intErr = hwFault || aMag > 25'(OVERCUR_MA);
		if (aMag > 25'(PEAK_MA)) begin
			anaCode = ANA_OVER;
		end else if (aMag > 25'(CLAMP_MA)) begin
			anaCode = analogReading[23] ? ANA_NEG_CLAMP : ANA_POS_CLAMP;
		end else begin
			anaCode = {~analogReading[23], analogReading[22:0]};
		end
		dClamped = digitalReading;
		if (digitalReading > 16'(DIG_CLAMP_A)) begin
			dClamped = 16'(DIG_CLAMP_A);
		end else if (digitalReading < -16'(DIG_CLAMP_A)) begin
			dClamped = -16'(DIG_CLAMP_A);
		end
		digCode = {~dClamped[15], dClamped[14:0]};
		supField = supplyMeasOk ? supplyStatus : SUPPLY_UNAVAIL;
		byte0 = 8'({seq, 4'h0} | ({6'h0, supField} << SUP_POS)
			| ({7'h0, intErr} << ERR_POS) | ({7'h0, plausFail} << PLAUS_POS));
		crcMsg = {byte0, anaCode, digCode, RESERVED_BYTE};
	end

	csf_crc8 u_crc (
		.msg(crcMsg),
		.crc(crcOut)
	);

	// period divider; whole clock cycles, so period error is the clock's own
	always_comb begin
		tick = (tickCnt == 32'(PERIOD_CYCLES - 1));
		next_tickCnt = tick ? 32'h0 : tickCnt + 32'h1;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tickCnt <= 32'h0;
		end else begin
			tickCnt <= next_tickCnt;
		end
	end

	// frame sequencer
	always_comb begin
		next_state = state;
		next_seq = seq;
		next_byteIdx = byteIdx;
		next_frame = frame;
		pushValid = 1'b0;
		pushData = frame[63 - 8 * byteIdx -: 8];
		case (state)
			ST_INIT: begin
				// supply judged once, just after reset release
				if (supplyMv < 16'(SUPPLY_MIN_MV) || supplyMv > 16'(SUPPLY_MAX_MV)) begin
					next_state = ST_HALT;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				// no sleep path: idle only waits for the next period
				if (tick) begin
					next_frame = {crcMsg, crcOut};
					next_byteIdx = 3'h0;
					next_state = ST_SEND;
				end
			end
			ST_SEND: begin
				pushValid = 1'b1;
				if (pushReady) begin
					next_byteIdx = byteIdx + 3'h1;
					if (byteIdx == 3'(FRAME_BYTES - 1)) begin
						next_seq = (seq == SEQ_LAST) ? SEQ_WRAP : seq + 4'h1;
						next_state = ST_IDLE;
					end
				end
			end
			ST_HALT: begin
				next_state = ST_HALT;
			end
			default: begin
				next_state = ST_INIT;
			end
		endcase
		next_running = (next_state == ST_IDLE) || (next_state == ST_SEND);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_INIT;
			seq <= SEQ_FIRST;
			byteIdx <= 3'h0;
			frame <= 64'h0;
			running <= 1'b0;
			frameId <= FRAME_ID;
		end else begin
			state <= next_state;
			seq <= next_seq;
			byteIdx <= next_byteIdx;
			frame <= next_frame;
			running <= next_running;
			frameId <= FRAME_ID;
		end
	end

	csf_fifo #(
		.WIDTH(9),
		.DEPTH(DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.inValid(pushValid),
		.inReady(pushReady),
		.inData({byteIdx == 3'(FRAME_BYTES - 1), pushData}),
		.outValid(txValid),
		.outReady(txReady),
		.outData({txLast, txData})
	);

	// checking aids: link byte count, cycles between period ticks
	logic [2:0] outCnt;
	logic [2:0] next_outCnt;
	logic [31:0] tickGap;
	logic [31:0] next_tickGap;
	logic tickSeen;
	logic next_tickSeen;
	logic [7:0] chkCrc;

	always_comb begin
		next_outCnt = outCnt;
		if (txValid && txReady) begin
			next_outCnt = outCnt + 3'h1;
		end
		next_tickGap = tick ? 32'h0 : tickGap + 32'h1;
		next_tickSeen = tickSeen || tick;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			outCnt <= 3'h0;
			tickGap <= 32'h0;
			tickSeen <= 1'b0;
		end else begin
			outCnt <= next_outCnt;
			tickGap <= next_tickGap;
			tickSeen <= next_tickSeen;
		end
	end

	// checksum recomputed from the stored payload
	csf_crc8 u_crcChk (
		.msg(frame[63:8]),
		.crc(chkCrc)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_frameDone;
		state == ST_SEND && pushReady && byteIdx == 3'h7;
	endsequence

	sequence s_load;
		state == ST_IDLE && tick;
	endsequence

	sequence s_waiting;
		txValid && !txReady;
	endsequence

	a_seq_wrap_one: assert property (s_frameDone ##0 seq == SEQ_LAST |=> seq == SEQ_WRAP)
		else $error("counter did not wrap to 1");
	a_seq_step_up: assert property (s_frameDone ##0 seq != SEQ_LAST |=> seq == $past(seq) + 4'h1)
		else $error("counter did not step by one");
	a_halt_stays_silent: assert property (state == ST_HALT |=> state == ST_HALT && !pushValid)
		else $error("frame activity after failed start-up");
	a_period_starts_frame: assert property (s_load |=> state == ST_SEND && byteIdx == 3'h0)
		else $error("period tick did not start a frame");
	a_overcur_error: assert property (s_load ##0 aMag > 25'(OVERCUR_MA) |=> frame[56 + ERR_POS])
		else $error("over-current not flagged");
	a_supply_unknown: assert property (s_load ##0 !supplyMeasOk |=> frame[59:58] == SUPPLY_UNAVAIL)
		else $error("supply status not 11");
	a_analog_peak: assert property (s_load ##0 aMag > 25'(PEAK_MA) |=> frame[55:32] == ANA_OVER)
		else $error("analog peak code wrong");
	a_digital_clamp: assert property (s_load
		##0 digitalReading > 16'(DIG_CLAMP_A) |=> frame[31:16] == DIG_POS_CLAMP)
		else $error("digital clamp code wrong");
	a_plaus_small_gap: assert property (s_load ##0 (aMag <= 25'(PLAUS_BAND_MA)
		&& diffMag > 28'(PLAUS_GAP_MA)) |=> frame[56 + PLAUS_POS])
		else $error("small-current gap not flagged");
	a_crc_tail_last: assert property (s_frameDone |-> pushData == chkCrc)
		else $error("checksum not the last byte");
	a_byte_holds: assert property (s_waiting
		|=> txValid && $stable(txData) && $stable(txLast))
		else $error("byte changed before it was taken");
	a_last_on_eighth: assert property (txValid |-> txLast == (outCnt == 3'h7))
		else $error("last flag not on the eighth byte");
	a_period_exact: assert property (tick && tickSeen
		|-> tickGap == 32'(PERIOD_CYCLES - 1))
		else $error("frame period not exact");
	a_running_holds: assert property (running |=> running)
		else $error("transmission stopped while operating");
	a_id_fixed: assert property (frameId == FRAME_ID)
		else $error("frame identifier changed");
	a_analog_clamp: assert property (s_load
		##0 (aMag > 25'(CLAMP_MA) && aMag <= 25'(PEAK_MA))
		|=> frame[55:32] == ($past(analogReading[23]) ? ANA_NEG_CLAMP : ANA_POS_CLAMP))
		else $error("analog clamp code wrong");
	a_analog_offset: assert property (s_load ##0 aMag <= 25'(CLAMP_MA)
		|=> frame[55:32] == $past(analogReading) + 24'h800000)
		else $error("analog offset code wrong");
	a_digital_neg_clamp: assert property (s_load
		##0 digitalReading < -16'(DIG_CLAMP_A) |=> frame[31:16] == DIG_NEG_CLAMP)
		else $error("negative digital clamp code wrong");
	a_digital_offset: assert property (s_load
		##0 (digitalReading <= 16'(DIG_CLAMP_A) && digitalReading >= -16'(DIG_CLAMP_A))
		|=> frame[31:16] == $past(digitalReading) + 16'h8000)
		else $error("digital offset code wrong");
	a_hw_fault_flag: assert property (s_load ##0 hwFault |=> frame[56 + ERR_POS])
		else $error("hardware fault not flagged");
	a_plaus_wide_gap: assert property (s_load
		##0 (aMag > 25'(PLAUS_BAND_MA) && aMag <= 25'(PLAUS_TOP_MA)
		&& 32'(diffMag) * 32'(100 / PLAUS_PCT) > 32'(aMag))
		|=> frame[56 + PLAUS_POS])
		else $error("wide-band gap not flagged");
	a_reserved_zero: assert property (state == ST_SEND
		|-> frame[15:8] == RESERVED_BYTE)
		else $error("reserved byte not zero");

endmodule

// ### bench/csf_bmc_model.sv
`timescale 1ns/1ps
module csf_bmc_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txLast,
	input wire logic stall,
	output logic txReady,
	output logic [63:0] frame,
	output logic got,
	output logic lastBad
);
	integer seed = 92947;
	logic [3:0] cnt;
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			txReady <= 1'b0;
			cnt <= 4'h0;
			got <= 1'b0;
			lastBad <= 1'b0;
			frame <= 64'h0;
		end else begin
			got <= 1'b0;
			if (txValid && txReady) begin
				frame <= {frame[55:0], txData};
				cnt <= txLast ? 4'h0 : cnt + 4'h1;
				got <= txLast;
				if (txLast != (cnt == 4'h7))
					lastBad <= 1'b1;
			end
			txReady <= !(stall && ($random(seed) % 4 == 0));
		end
	end
endmodule

// ### bench/current_sensor_can_frame_builder_test.sv
`timescale 1ns/1ps
module current_sensor_can_frame_builder_test;
	import csf_pkg::*;
	localparam int PER = 80;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic signed [23:0] analogReading = 24'h0;
	logic signed [15:0] digitalReading = 16'h0;
	logic [15:0] supplyMv = 16'h1e78;
	logic supplyMeasOk = 1'b1;
	logic [1:0] supplyStatus = 2'h0;
	logic hwFault = 1'b0;
	logic stall = 1'b0;
	logic txReady, txValid, txLast, running, got, lastBad, seenValid;
	logic [10:0] frameId;
	logic [7:0] txData;
	logic [63:0] frame, want;
	logic [4:0] firstTop;
	logic [3:0] seq = 4'h0;
	logic [15:0] mvs [3] = '{16'h1e77, 16'h3f49, 16'h3f48};
	integer seed = 92947;
	integer failures = 0;
	integer n_tests = 0;
	integer cycles = 0;
	int a, d, lastT;
	int ca [13] = '{0, 1, -1, 1550001, -1550001, 1600001, 1700001, -1700001,
		220000, 220000, 1000000, 1000000, 1500001};
	int cd [13] = '{0, 1, -1, 1551, -1551, 1600, 1700, -1700, 176, 175, 799, 800, 0};

	csf_frame_builder #(.PERIOD_CYCLES(PER), .DEPTH(FIFO_DEPTH)) dut_u (.sys_clk(sys_clk),
		.nrst(nrst), .analogReading(analogReading), .digitalReading(digitalReading),
		.supplyMv(supplyMv), .supplyMeasOk(supplyMeasOk), .supplyStatus(supplyStatus),
		.hwFault(hwFault), .txReady(txReady), .frameId(frameId), .txData(txData),
		.txValid(txValid), .txLast(txLast), .running(running));
	csf_bmc_model bmc_u (.sys_clk(sys_clk), .nrst(nrst), .txData(txData), .txValid(txValid),
		.txLast(txLast), .stall(stall), .txReady(txReady), .frame(frame), .got(got),
		.lastBad(lastBad));

	always #2.5 sys_clk = ~sys_clk;

	function automatic logic [7:0] crc(logic [55:0] b);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 55; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h1d : 8'h00);
		return ~c;
	endfunction

	function automatic logic [23:0] anaCode(int x);
		if (x > 1700000 || x < -1700000)
			return 24'hffffff;
		if (x > 1550000)
			return 24'h97a6b0;
		if (x < -1550000)
			return 24'h685950;
		return 24'(32'h800000 + x);
	endfunction

	function automatic logic [15:0] digCode(int x);
		if (x > 1550)
			return 16'h860e;
		if (x < -1550)
			return 16'h79f2;
		return 16'(32'h8000 + x);
	endfunction

	function automatic logic [63:0] expFrame(int x, int y);
		int m, g;
		logic p;
		logic [55:0] b;
		m = x < 0 ? -x : x;
		g = x - y * 1000;
		g = g < 0 ? -g : g;
		p = m <= 220000 ? g > 44000 : (m <= 1500000 && g * 100 > m * 20);
		b = {seq, supplyMeasOk ? supplyStatus : 2'h3, hwFault || m > 1600000, p,
			anaCode(x), digCode(y), 8'h00};
		return {b, crc(b)};
	endfunction

	task automatic check(logic [63:0] seen, logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic doReset(logic [15:0] mv);
		@(posedge sys_clk);
		nrst <= 1'b0;
		supplyMv <= mv;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
	endtask

	task automatic waitFrame();
		while (got !== 1'b1)
			@(negedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		doReset(16'h1e78);
		for (int i = 0; i < 24; i++) begin
			@(posedge sys_clk);
			a = i < 13 ? ca[i] : $random(seed) % 1800000;
			d = i < 13 ? cd[i] : a / 1000 + $random(seed) % 60;
			analogReading <= 24'(a);
			digitalReading <= 16'(d);
			hwFault <= i < 13 ? i == 2 : $random(seed) % 5 == 0;
			supplyMeasOk <= i != 1;
			supplyStatus <= 2'($random(seed));
			stall <= i > 6;
			#1;
			want = expFrame(a, d);
			waitFrame();
			check(frame[63:56], want[63:56]);
			check(frame[55:32], want[55:32]);
			check(frame[31:16], want[31:16]);
			check(frame[15:0], want[15:0]);
			if (i > 0 && i < 7)
				check(64'(cycles - lastT), 64'(PER));
			lastT = cycles;
			seq = seq == 4'hf ? 4'h1 : seq + 4'h1;
		end
		check(lastBad, 1'b0);
		check(frameId, 11'h3c2);
		for (int j = 0; j < 3; j++) begin
			doReset(mvs[j]);
			seenValid = 1'b0;
			firstTop = 5'h1f;
			repeat (3 * PER) begin
				@(negedge sys_clk);
				seenValid |= txValid;
				if (got === 1'b1 && firstTop == 5'h1f)
					firstTop = {1'b0, frame[63:60]};
			end
			check(running, j == 2);
			check(seenValid, j == 2);
			check(firstTop, j == 2 ? 5'h00 : 5'h1f);
		end
		complete_run();
	end
endmodule
